/* rtl/spg_otp_pages.sv */
`timescale 1ns/10ps
`include "spg_cfg.svh"
// Overview of operation
// - three independent lockable pages beside main array
// - unique id needs opcode plus four dummy bytes
// - 64-bit id shifted out on falling clock
// - erase opcode, three address bytes, start on release
// - erase self-timed within page program time
// - lowest address byte ignored on erase
// - erase needs release right after bit A0
// - busy reported during erase, cleared at end
// - aborted or protected erase clears write enable
// - locked page ignores erase
// - erase page select from upper address fields
// - program/read page select plus byte offset
// - program overwrites shared 256-byte buffer
// - program opcode then three address bytes
// - read opcode, address, one dummy byte
// - sequential read wraps with no delay
// - release ends read, output released
// - status one: latch bit1, busy bit0
// - status two lock bits 3..5, default unlocked
module spg_otp_pages #(
    parameter int unsigned     PPT_CYC   = `SPG_PPT_CYC,
    parameter spg_pkg::spg_uid_t UID_VALUE = 64'h0123_4567_89ab_cdef // arbitrary value
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              mosi,
    input  wire spg_pkg::spg_lock_t lock_set,
    output logic                   miso,
    output logic                   miso_oe,
    output logic                   write_enable_latch,
    output logic                   ready_busy_flag,
    output logic                   page1_lock_bit,
    output logic                   page2_lock_bit,
    output logic                   page3_lock_bit
);
    import spg_pkg::*;

    logic [7:0]            mem_r [0:`SPG_MEM_BYTES-1];
    logic [7:0]            buf_r [0:`SPG_PG_BYTES-1];
    logic [`SPG_PG_BYTES-1:0] ldm_r;
    logic                  in_frame_r;
    logic [5:0]            cnt_r, cnt_nxt;
    logic [2:0]            bit3_r, bit3_nxt;
    logic [7:0]            sr_nxt, sr_r, op_r, ptr_r, obyte;
    logic [23:0]           addr_r;
    logic [4:0]            st_s1_r, st_s2_r;
    logic                  oph, miso_r, oe_r;
    logic                  cs_s1_r, cs_s2_r, cs_d_r, fe;
    spg_lock_t             lock_r;
    logic                  wel_r, ers_r;
    logic [1:0]            pg_r, pgi;
    spg_state_e            st_r;
    logic [`SPG_TMR_W-1:0] tmr_r;
    logic                  pg_ok, go_ers, go_prg, abort, byte_done;
    logic [9:0]            ridx, widx;

    ////////////////////////////////////////////////////////////////////////
    // link side, sclk domain; cs_n high clears only the frame flag and the output enable so the
    // counters stay frozen for the mclk side to decode after release

    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            in_frame_r <= 1'b0;
        else
            in_frame_r <= 1'b1;
    end

    // bit counting restarts on the first edge of a frame
    always_comb
    begin
        cnt_nxt  = !in_frame_r ? 6'h01 : (cnt_r == `SPG_CNT_MAX ? cnt_r : cnt_r + 6'h01);
        bit3_nxt = !in_frame_r ? 3'h1 : bit3_r + 3'h1;
        sr_nxt   = {sr_r[6:0], mosi};
        byte_done = (bit3_nxt == 3'h0) && (cnt_nxt >= `SPG_DAT_BITS);
    end

    always_ff @(posedge sclk)
    begin
        cnt_r  <= cnt_nxt;
        bit3_r <= bit3_nxt;
        sr_r   <= sr_nxt;
        if (cnt_nxt == `SPG_OPC_BITS)
            op_r <= sr_nxt;
        if (cnt_nxt > `SPG_OPC_BITS && cnt_nxt <= `SPG_ADR_BITS)
            addr_r <= {addr_r[22:0], mosi};
    end

    // status into the link domain; a level, so a plain two-flop stage
    always_ff @(posedge sclk)
    begin
        st_s1_r <= {lock_r, wel_r, st_r == SPG_BUSY};
        st_s2_r <= st_s1_r;
    end
    // byte pointer: start offset from A7-A0 (zero for the id), bumps at each data byte end
    always_ff @(posedge sclk)
    begin
        if (cnt_nxt == `SPG_ADR_BITS)
            ptr_r <= (op_r == `SPG_OP_UID) ? 8'h00 : {addr_r[6:0], mosi};
        else if (byte_done && (op_r == `SPG_OP_PROG || cnt_nxt > `SPG_DAT_BITS)) // dummy bytes never bump
            ptr_r <= ptr_r + 8'h01;
    end
    // buffer load; blocked while busy since the walker reads it then
    always_ff @(posedge sclk)
    begin
        if (cnt_nxt == `SPG_OPC_BITS && sr_nxt == `SPG_OP_PROG && !st_s2_r[0])
            ldm_r <= '0;
        else if (byte_done && op_r == `SPG_OP_PROG && !st_s2_r[0])
        begin
            buf_r[ptr_r] <= sr_nxt;
            ldm_r[ptr_r] <= 1'b1;
        end
    end

    // page index from A13-A12; only valid once pg_ok holds
    always_comb
    begin
        pgi   = addr_r[13:12] - 2'h1;
        pg_ok = addr_r[23:16] == `SPG_HI_ZERO && addr_r[11:8] == `SPG_MID_ZERO
                && addr_r[15:12] >= `SPG_PG_FIRST && addr_r[15:12] <= `SPG_PG_LAST;
        ridx  = {pgi, ptr_r};
    end

    // byte on the wire; an invalid page reads as erased
    always_comb
    begin
        obyte = `SPG_ERASED;
        oph   = 1'b0;
        unique case (op_r)
            `SPG_OP_STAT1:
            begin
                obyte = {6'h00, st_s2_r[`SPG_ST1_WEL], st_s2_r[`SPG_ST1_BUSY]};
                oph   = cnt_r >= `SPG_OPC_BITS;
            end
            `SPG_OP_STAT2:
            begin
                obyte = {2'h0, st_s2_r[4:2], 3'h0};
                oph   = cnt_r >= `SPG_OPC_BITS;
            end
            `SPG_OP_UID:
            begin
                obyte = UID_VALUE[63 - 8 * ptr_r[2:0] -: 8];
                oph   = cnt_r >= `SPG_DAT_BITS;
            end
            `SPG_OP_READ:
            begin
                if (pg_ok)
                    obyte = mem_r[ridx];
                oph = cnt_r >= `SPG_DAT_BITS;
            end
            default:
                oph = 1'b0;
        endcase
    end
    // shift out on the falling edge; release parks the pin at once
    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
            oe_r <= 1'b0;
        else
            oe_r <= oph && in_frame_r;
    end
    always_ff @(negedge sclk)
    begin
        miso_r <= obyte[~bit3_r];
    end
    assign miso    = miso_r;
    assign miso_oe = oe_r;
    ////////////////////////////////////////////////////////////////////////
    // core side, mclk domain; frame end seen through a two-flop stage,
    // after which the frozen link counters are safe to read

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_d_r  <= 1'b1;
        end
        else
        begin
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            cs_d_r  <= cs_s2_r;
        end
    end
    assign fe = cs_s2_r && !cs_d_r;
    // command decode at frame end; commands while busy are dropped
    always_comb
    begin
        go_ers = 1'b0;
        go_prg = 1'b0;
        abort  = 1'b0;
        if (fe && st_r == SPG_IDLE && cnt_r >= `SPG_OPC_BITS && wel_r)
        begin
            if (op_r == `SPG_OP_ERASE)
            begin
                // exact count: release right after A0; A7-A0 unused
                if (cnt_r == `SPG_ADR_BITS && pg_ok && !lock_r[pgi])
                    go_ers = 1'b1;
                else
                    abort = 1'b1;
            end
            if (op_r == `SPG_OP_PROG)
            begin
                if (cnt_r >= `SPG_DAT_BITS && bit3_r == 3'h0 && pg_ok && !lock_r[pgi])
                    go_prg = 1'b1;
                else
                    abort = 1'b1;
            end
        end
    end

    // write enable latch
    always_ff @(posedge mclk)
    begin
        if (reset)
            wel_r <= 1'b0;
        else if (abort)
            wel_r <= 1'b0;
        else if (st_r == SPG_BUSY && tmr_r == `SPG_TMR_W'(PPT_CYC - 1))
            wel_r <= 1'b0;
        else if (fe && st_r == SPG_IDLE && cnt_r == `SPG_OPC_BITS && op_r == `SPG_OP_WREN)
            wel_r <= 1'b1;
        else if (fe && st_r == SPG_IDLE && cnt_r == `SPG_OPC_BITS && op_r == `SPG_OP_WRDI)
            wel_r <= 1'b0;
    end

    // lock bits only ever set; reset alone clears them
    always_ff @(posedge mclk)
    begin
        if (reset)
            lock_r <= '0;
        else
            lock_r <= lock_r | lock_set;
    end

    // self-timed cycle: walk the 256 bytes, then wait out the rest
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_r  <= SPG_IDLE;
            tmr_r <= '0;
            ers_r <= 1'b0;
            pg_r  <= 2'h0;
        end
        else
        begin
            unique case (st_r)
                SPG_IDLE:
                begin
                    tmr_r <= '0;
                    if (go_ers || go_prg)
                    begin
                        st_r  <= SPG_BUSY;
                        ers_r <= go_ers;
                        pg_r  <= pgi;
                    end
                end
                SPG_BUSY:
                begin
                    tmr_r <= tmr_r + 1'b1;
                    if (tmr_r == `SPG_TMR_W'(PPT_CYC - 1))
                        st_r <= SPG_IDLE;
                end
            endcase
        end
    end
    assign widx = {pg_r, tmr_r[7:0]};
    // array update: erase fills, program clears only loaded bytes' zeros
    always_ff @(posedge mclk)
    begin
        if (st_r == SPG_BUSY && tmr_r < `SPG_TMR_W'(`SPG_PG_BYTES))
        begin
            if (ers_r)
                mem_r[widx] <= `SPG_ERASED;
            else if (ldm_r[tmr_r[7:0]])
                mem_r[widx] <= mem_r[widx] & buf_r[tmr_r[7:0]];
        end
    end

    assign write_enable_latch = wel_r;
    assign ready_busy_flag    = st_r == SPG_BUSY;
    assign page1_lock_bit     = lock_r[0];
    assign page2_lock_bit     = lock_r[1];
    assign page3_lock_bit     = lock_r[2];

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_busy_hold;
        @(posedge mclk) disable iff (reset) $rose(ready_busy_flag) |-> ready_busy_flag [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    property p_start_wel;
        @(posedge mclk) disable iff (reset) $rose(ready_busy_flag) |-> $past(wel_r);
    endproperty
    a_start_wel: assert property (p_start_wel) else $error("cycle started without latch");
    property p_lock_ign;
        @(posedge mclk) disable iff (reset)
            fe && op_r == `SPG_OP_ERASE && pg_ok && lock_r[pgi] && !ready_busy_flag |=> !ready_busy_flag;
    endproperty
    a_lock_ign: assert property (p_lock_ign) else $error("locked page erased");
    property p_abort_wel;
        @(posedge mclk) disable iff (reset)
            fe && op_r == `SPG_OP_ERASE && cnt_r != `SPG_ADR_BITS && cnt_r >= `SPG_OPC_BITS
            && !ready_busy_flag |=> !wel_r && !ready_busy_flag;
    endproperty
    a_abort_wel: assert property (p_abort_wel) else $error("bad erase frame not aborted");
    property p_ers_go;
        @(posedge mclk) disable iff (reset) go_ers |=> ready_busy_flag && ers_r;
    endproperty
    a_ers_go: assert property (p_ers_go) else $error("erase not started");
    property p_rel_hiz;
        @(posedge mclk) disable iff (reset) cs_s2_r |-> !miso_oe;
    endproperty
    a_rel_hiz: assert property (p_rel_hiz) else $error("output driven after release");
    property p_wrap;
        @(posedge sclk) disable iff (cs_n)
            in_frame_r && op_r == `SPG_OP_READ && cnt_r > `SPG_DAT_BITS && bit3_r == 3'h7
            && ptr_r == 8'hff |=> ptr_r == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("read did not wrap");
    property p_uid_dummy;
        @(posedge sclk) disable iff (cs_n)
            in_frame_r && op_r == `SPG_OP_UID && cnt_r < `SPG_DAT_BITS |-> !oph;
    endproperty
    a_uid_dummy: assert property (p_uid_dummy) else $error("id out before dummies");
endmodule : spg_otp_pages

/* rtl/spg_cfg.svh */
`ifndef SPG_CFG_SVH
`define SPG_CFG_SVH
// opcodes
`define SPG_OP_UID      8'h4b
`define SPG_OP_ERASE    8'h44
`define SPG_OP_PROG     8'h42
`define SPG_OP_READ     8'h48
`define SPG_OP_STAT1    8'h05
`define SPG_OP_STAT2    8'h35
`define SPG_OP_WREN     8'h06
`define SPG_OP_WRDI     8'h04
// frame bit counts
`define SPG_OPC_BITS    6'd8
`define SPG_ADR_BITS    6'd32
`define SPG_DAT_BITS    6'd40
`define SPG_CNT_MAX     6'h3f
// page select fields
`define SPG_HI_ZERO     8'h00
`define SPG_MID_ZERO    4'h0
`define SPG_PG_FIRST    4'h1
`define SPG_PG_LAST     4'h3
`define SPG_PG_BYTES    256
`define SPG_MEM_BYTES   768
`define SPG_ERASED      8'hff
// status bit positions
`define SPG_ST1_BUSY    0
`define SPG_ST1_WEL     1
`define SPG_ST2_LB_LO   3
// timing: page program time (longest), mclk period
`define SPG_PPT_NS      800000
`define SPG_MCLK_NS     50
`define SPG_PPT_CYC     (`SPG_PPT_NS / `SPG_MCLK_NS)
`define SPG_TMR_W       24
`endif

/* rtl/spg_pkg.sv */
package spg_pkg;
    typedef logic [2:0] spg_lock_t;
    typedef enum logic {SPG_IDLE, SPG_BUSY} spg_state_e;
    typedef logic [63:0] spg_uid_t;
endpackage : spg_pkg

/* tb/spg_spi_host.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// host end of the serial link, mode 0; the clock stands low between frames
module spg_spi_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    logic [63:0] rx;      // bits taken from miso after the command bits
    logic        oe_seen; // miso_oe was high at every capture
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // nb command bits of tx msb first, then nr read clocks; mosi toggles there
    // so the device never sees a steady stale level
    task automatic xfer(input logic [71:0] tx, input int nb, input int nr);
        rx = '0;
        oe_seen = 1'b1;
        #3.3 cs_n = 1'b0;
        for (int i = 0; i < nb + nr; i++)
        begin
            mosi = (i < nb) ? tx[nb-1-i] : ~mosi; // opcode, address, dummy
            #7.5 sclk = 1'b1;
            if (i >= nb)
            begin
                rx = {rx[62:0], miso_oe ? miso : ~miso}; // no pull on the line: a released pin reads wrong
                oe_seen = oe_seen & miso_oe;
            end
            #7.5 sclk = 1'b0;
        end
        #7.5 cs_n = 1'b1; // release right after the last bit
        mosi = ~mosi;
        #300; // deselect gap above the 200 ns minimum
    endtask : xfer
endmodule : spg_spi_host

/* tb/tb_otp_security_page_access.sv */
`timescale 1ns/10ps
`include "spg_cfg.svh"
`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module tb_otp_security_page_access;
    import spg_pkg::*;
    localparam int unsigned PPT = 300; // short cycle time, still longer than a page walk
    localparam spg_uid_t    UID = 64'h0f1e_2d3c_4b5a_6978; // arbitrary value
    logic      mclk = 1'b0;
    logic      reset = 1'b1;
    spg_lock_t lock_set = 3'h0;
    logic      sclk, cs_n, mosi, miso, miso_oe;
    logic      write_enable_latch, ready_busy_flag, page1_lock_bit, page2_lock_bit, page3_lock_bit;
    int        n_mismatch = 0;
    int        n_compared = 0;
    ////////////////////////////////////////////////////////////////////////////
    always #25 mclk = ~mclk;
    spg_otp_pages #(.PPT_CYC(PPT), .UID_VALUE(UID)) spg_otp_pages_i (
        .mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .lock_set(lock_set),
        .miso(miso), .miso_oe(miso_oe), .write_enable_latch(write_enable_latch),
        .ready_busy_flag(ready_busy_flag), .page1_lock_bit(page1_lock_bit),
        .page2_lock_bit(page2_lock_bit), .page3_lock_bit(page3_lock_bit));
    spg_spi_host spg_spi_host_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
    ////////////////////////////////////////////////////////////////////////////
    // one frame, then sample on a falling mclk edge where all outputs are settled
    task automatic sx(input logic [71:0] tx, input int nb, input int nr);
        spg_spi_host_i.xfer(tx, nb, nr);
        @(negedge mclk);
    endtask : sx
    // write enable, one guarded command, status poll, bounded wait for the end
    task automatic op(input logic [71:0] tx, input int nb, input logic busy_exp);
        int n;
        n = 0;
        sx({64'h0, `SPG_OP_WREN}, 8, 0);
        `CHK(write_enable_latch, 1'b1) // latch set first
        sx(tx, nb, 0);
        `CHK(ready_busy_flag, busy_exp) // cycle starts only for a valid frame
        sx({64'h0, `SPG_OP_STAT1}, 8, 8);
        `CHK(spg_spi_host_i.rx[1:0], {busy_exp, busy_exp}) // polled latch and busy
        while (ready_busy_flag !== 1'b0 && n < PPT + 100)
        begin
            @(negedge mclk);
            n++;
        end
        `CHK(n > PPT - 40, busy_exp) // busy stands the cycle time
        `CHK(ready_busy_flag, 1'b0) // self-timed end
        `CHK(write_enable_latch, 1'b0) // latch cleared at end or abort
    endtask : op
    task automatic test_end(input string s);
        $display("test %s done", s);
    endtask : test_end
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////
    // main sequence: each group leaves the pages in a known state for the next
    initial
    begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        `CHK({write_enable_latch, ready_busy_flag, page3_lock_bit, page2_lock_bit, page1_lock_bit}, 5'h00)
        test_end("reset");
        sx({32'h0, `SPG_OP_UID, 32'h0}, 40, 64); // four dummy bytes
        `CHK(spg_spi_host_i.rx, UID) // id msb first
        `CHK(spg_spi_host_i.oe_seen, 1'b1) // driven while data flows
        `CHK(miso_oe, 1'b0) // released after the frame
        test_end("unique id");
        op({8'h44, 24'h0010ab}, 32, 1'b1); // low byte ignored
        op({8'h44, 24'h0030ff}, 32, 1'b1); // independent third page
        op({8'h42, 24'h0010fe, 16'h3ca5}, 48, 1'b1); // two bytes from offset fe
        sx({8'h48, 24'h0010fd, 8'h00}, 40, 32);
        `CHK(spg_spi_host_i.rx[31:0], 32'hff3c_a5ff) // offsets fd..ff then wrap
        sx({8'h48, 24'h0030fd, 8'h00}, 40, 5);
        `CHK(spg_spi_host_i.rx[4:0], 5'h1f) // erased page, frame cut mid-byte
        `CHK(miso_oe, 1'b0) // output released
        test_end("erase program read");
        op(31'h2200_0800, 31, 1'b0); // short address
        op({32'h4400_1000, 1'b0}, 33, 1'b0); // off byte boundary
        op({8'h44, 24'h004000}, 32, 1'b0); // page field out of range
        op({8'h44, 24'h001100}, 32, 1'b0); // middle field nonzero
        op({8'h42, 24'h001000, 4'h0}, 36, 1'b0); // program cut inside a data byte
        sx({64'h0, `SPG_OP_WREN}, 8, 0);
        sx({64'h0, `SPG_OP_WRDI}, 8, 0);
        `CHK(write_enable_latch, 1'b0) // write disable clears the latch
        sx({8'h44, 24'h001000}, 32, 0);
        `CHK(ready_busy_flag, 1'b0) // no erase without the latch
        test_end("aborts");
        @(posedge mclk);
        lock_set <= 3'h2;
        @(posedge mclk);
        lock_set <= 3'h0;
        @(negedge mclk);
        `CHK({page3_lock_bit, page2_lock_bit, page1_lock_bit}, 3'h2)
        sx({64'h0, `SPG_OP_STAT2}, 8, 8);
        `CHK(spg_spi_host_i.rx[7:0], 8'h10) // lock bits at 3..5
        op({8'h44, 24'h002000}, 32, 1'b0); // locked page ignores erase
        sx({8'h48, 24'h0010fe, 8'h00}, 40, 8);
        `CHK(spg_spi_host_i.rx[7:0], 8'h3c) // no abort touched the page
        test_end("lock");
        report_and_stop;
    end
    // about 1400 mclk of work expected; the limit leaves ample margin
    initial
    begin
        #1000000;
        n_mismatch++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        report_and_stop;
    end
endmodule : tb_otp_security_page_access
